// file: shared/ppp_defs.svh
// register offsets, reset values and pin positions of the pin port
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH

`define PPP_ADDR_W 8
`define PPP_HALF_W 16
`define PPP_PIN_N 32

`define PPP_OFF_MODE_LOW 8'h70
`define PPP_OFF_DIR_LOW 8'h72
`define PPP_OFF_DATA_LOW 8'h74
`define PPP_OFF_MODE_HIGH 8'h76
`define PPP_OFF_DIR_HIGH 8'h78
`define PPP_OFF_DATA_HIGH 8'h7A

`define PPP_RST_DIR_LOW 16'hFC0F
`define PPP_RST_DIR_HIGH 16'hFFFF
`define PPP_RST_MODE 16'h0000
`define PPP_RST_RDATA 16'h0000

// emulator pins 26 and 29, as bits 10 and 13 of the high half
`define PPP_EMU_MASK_HIGH 16'h2400
`define PPP_PULL_DOWN_PIN 1

`endif

// file: shared/ppp_pkg.sv
// types shared by the pin port design
package ppp_pkg;
    // encoding is {mode bit, direction bit}
    typedef enum logic [1:0] {
        FUNC_NORMAL = 2'h0,
        FUNC_IN_PULL = 2'h1,
        FUNC_OUT = 2'h2,
        FUNC_IN_NOPULL = 2'h3
    } ppp_func_t;
endpackage

// file: design/ppp_pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module ppp_pin_sync #(
    parameter int WIDTH = 33
) (
    // clock
    input wire logic clk,
    // asynchronous levels in, filtered levels out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] level_ff;

    // no reset: the strap must be seen while reset is held
    always_ff @(posedge clk) begin
        stage1_ff <= asyncIn;
        stage2_ff <= stage1_ff;
        stage3_ff <= stage2_ff;
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2_ff[i] == stage3_ff[i]) begin
                level_ff[i] <= stage3_ff[i];
            end
        end
    end

    assign syncOut = level_ff;
endmodule

// file: design/ppp_port.sv
// 32-pin programmable port: registers, pin muxing and pull control
`timescale 1ns/1ns
`include "ppp_defs.svh"
module ppp_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [`PPP_ADDR_W-1:0] regAddr,
    input wire logic [`PPP_HALF_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [`PPP_HALF_W-1:0] regRdData,
    // strap, active low, sampled during reset
    input wire logic upperByteEnN,
    // device pins
    input wire logic [`PPP_PIN_N-1:0] pinIn,
    output logic [`PPP_PIN_N-1:0] pinOut,
    output logic [`PPP_PIN_N-1:0] pinOe,
    output logic [`PPP_PIN_N-1:0] pinPullUp,
    output logic [`PPP_PIN_N-1:0] pinPullDown,
    // normal-function peripheral side
    input wire logic [`PPP_PIN_N-1:0] funcOut,
    input wire logic [`PPP_PIN_N-1:0] funcOe,
    output logic [`PPP_PIN_N-1:0] funcIn
);
    logic [`PPP_HALF_W-1:0] modeLow_ff;
    logic [`PPP_HALF_W-1:0] modeHigh_ff;
    logic [`PPP_HALF_W-1:0] dirLow_ff;
    logic [`PPP_HALF_W-1:0] dirHigh_ff;
    logic [`PPP_PIN_N-1:0] data_ff;
    logic [`PPP_PIN_N-1:0] nxt_data;
    logic [`PPP_HALF_W-1:0] rdData_ff;
    logic [`PPP_HALF_W-1:0] nxt_rdData;
    logic [`PPP_PIN_N-1:0] pinOut_ff;
    logic [`PPP_PIN_N-1:0] pinOe_ff;
    logic [`PPP_PIN_N-1:0] pullUp_ff;
    logic [`PPP_PIN_N-1:0] pullDown_ff;
    logic [`PPP_PIN_N:0] syncLevel;
    logic [`PPP_PIN_N-1:0] pinLevel;
    logic strapLow;
    logic [`PPP_PIN_N-1:0] modeAll;
    logic [`PPP_PIN_N-1:0] dirAll;
    logic [`PPP_HALF_W-1:0] emuMask;
    ppp_pkg::ppp_func_t funcAll [`PPP_PIN_N];
    logic wrModeLow;
    logic wrModeHigh;
    logic wrDirLow;
    logic wrDirHigh;
    logic wrDataLow;
    logic wrDataHigh;

    function automatic ppp_pkg::ppp_func_t pinFunc(input logic m,
                                                   input logic d);
        pinFunc = ppp_pkg::ppp_func_t'({m, d});
    endfunction

    function automatic logic hit(input logic [`PPP_ADDR_W-1:0] a,
                                 input logic [`PPP_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // only one pin has a pull-down; all others pull up
    function automatic logic isPullDownPin(input int i);
        isPullDownPin = (i == `PPP_PULL_DOWN_PIN);
    endfunction

    // write strobe of the half that holds pin i
    function automatic logic dataWrFor(input int i,
                                       input logic wrLow,
                                       input logic wrHigh);
        dataWrFor = (i < `PPP_HALF_W) ? wrLow : wrHigh;
    endfunction

    // next data bit: an input pin's level wins over a software write
    function automatic logic dataNext(input logic dir,
                                      input logic lvl,
                                      input logic wr,
                                      input logic wbit,
                                      input logic old);
        if (dir) begin
            dataNext = lvl;
        end else if (wr) begin
            dataNext = wbit;
        end else begin
            dataNext = old;
        end
    endfunction

    // drive enable per pin function; input functions never drive
    function automatic logic oeFor(input ppp_pkg::ppp_func_t f,
                                   input logic fOe);
        oeFor = 1'b0;
        case (f)
            ppp_pkg::FUNC_NORMAL: begin
                oeFor = fOe;
            end
            ppp_pkg::FUNC_IN_PULL: begin
                oeFor = 1'b0;
            end
            ppp_pkg::FUNC_OUT: begin
                oeFor = 1'b1;
            end
            ppp_pkg::FUNC_IN_NOPULL: begin
                oeFor = 1'b0;
            end
            default: begin
                oeFor = 1'b0;
            end
        endcase
    endfunction

    // drive value per pin function; held low in the two input functions
    function automatic logic outFor(input ppp_pkg::ppp_func_t f,
                                    input logic fOut,
                                    input logic dat);
        outFor = 1'b0;
        case (f)
            ppp_pkg::FUNC_NORMAL: begin
                outFor = fOut;
            end
            ppp_pkg::FUNC_IN_PULL: begin
                outFor = 1'b0;
            end
            ppp_pkg::FUNC_OUT: begin
                outFor = dat;
            end
            ppp_pkg::FUNC_IN_NOPULL: begin
                outFor = 1'b0;
            end
            default: begin
                outFor = 1'b0;
            end
        endcase
    endfunction

    // pull-up only for a pulled input that is not the pull-down pin
    function automatic logic pullUpFor(input ppp_pkg::ppp_func_t f,
                                       input logic pd);
        pullUpFor = 1'b0;
        case (f)
            ppp_pkg::FUNC_NORMAL: begin
                pullUpFor = 1'b0;
            end
            ppp_pkg::FUNC_IN_PULL: begin
                pullUpFor = !pd;
            end
            ppp_pkg::FUNC_OUT: begin
                pullUpFor = 1'b0;
            end
            ppp_pkg::FUNC_IN_NOPULL: begin
                pullUpFor = 1'b0;
            end
            default: begin
                pullUpFor = 1'b0;
            end
        endcase
    endfunction

    // pull-down only for the pull-down pin as a pulled input
    function automatic logic pullDownFor(input ppp_pkg::ppp_func_t f,
                                         input logic pd);
        pullDownFor = 1'b0;
        case (f)
            ppp_pkg::FUNC_NORMAL: begin
                pullDownFor = 1'b0;
            end
            ppp_pkg::FUNC_IN_PULL: begin
                pullDownFor = pd;
            end
            ppp_pkg::FUNC_OUT: begin
                pullDownFor = 1'b0;
            end
            ppp_pkg::FUNC_IN_NOPULL: begin
                pullDownFor = 1'b0;
            end
            default: begin
                pullDownFor = 1'b0;
            end
        endcase
    endfunction

    ppp_pin_sync #(
        .WIDTH(`PPP_PIN_N + 1)
    ) u_sync (
        .clk(clk),
        .asyncIn({upperByteEnN, pinIn}),
        .syncOut(syncLevel)
    );

    assign pinLevel = syncLevel[`PPP_PIN_N-1:0];
    assign strapLow = ~syncLevel[`PPP_PIN_N];
    assign emuMask = strapLow ? `PPP_EMU_MASK_HIGH : `PPP_RST_MODE;
    assign modeAll = {modeHigh_ff, modeLow_ff};
    assign dirAll = {dirHigh_ff, dirLow_ff};

    // write strobes per register; unmapped offsets match none
    assign wrModeLow = regWrEn && hit(regAddr, `PPP_OFF_MODE_LOW);
    assign wrModeHigh = regWrEn && hit(regAddr, `PPP_OFF_MODE_HIGH);
    assign wrDirLow = regWrEn && hit(regAddr, `PPP_OFF_DIR_LOW);
    assign wrDirHigh = regWrEn && hit(regAddr, `PPP_OFF_DIR_HIGH);
    assign wrDataLow = regWrEn && hit(regAddr, `PPP_OFF_DATA_LOW);
    assign wrDataHigh = regWrEn && hit(regAddr, `PPP_OFF_DATA_HIGH);

    // function of every pin from its mode and direction bit
    always_comb begin
        for (int i = 0; i < `PPP_PIN_N; i++) begin
            funcAll[i] = pinFunc(modeAll[i], dirAll[i]);
        end
    end

    // mode register, low half
    always_ff @(posedge clk) begin
        if (rst) begin
            modeLow_ff <= `PPP_RST_MODE;
        end else if (wrModeLow) begin
            modeLow_ff <= regWrData;
        end
    end

    // mode register, high half
    always_ff @(posedge clk) begin
        if (rst) begin
            modeHigh_ff <= `PPP_RST_MODE;
        end else if (wrModeHigh) begin
            modeHigh_ff <= regWrData;
        end
    end

    // direction register, low half
    always_ff @(posedge clk) begin
        if (rst) begin
            dirLow_ff <= `PPP_RST_DIR_LOW;
        end else if (wrDirLow) begin
            dirLow_ff <= regWrData;
        end
    end

    // direction register, high half; strap is read while reset is held
    always_ff @(posedge clk) begin
        if (rst) begin
            dirHigh_ff <= `PPP_RST_DIR_HIGH & ~emuMask;
        end else if (wrDirHigh) begin
            dirHigh_ff <= regWrData;
        end
    end

    // data register: inputs follow the pin, others keep software value
    always_comb begin
        nxt_data = data_ff;
        for (int i = 0; i < `PPP_PIN_N; i++) begin
            nxt_data[i] = dataNext(dirAll[i],
                                   pinLevel[i],
                                   dataWrFor(i, wrDataLow, wrDataHigh),
                                   regWrData[i % `PPP_HALF_W],
                                   data_ff[i]);
        end
    end

    // undefined after reset until written or loaded
    always_ff @(posedge clk) begin
        data_ff <= nxt_data;
    end

    // read port; unmapped addresses read zero
    always_comb begin
        nxt_rdData = `PPP_RST_RDATA;
        case (regAddr)
            `PPP_OFF_MODE_LOW: nxt_rdData = modeLow_ff;
            `PPP_OFF_MODE_HIGH: nxt_rdData = modeHigh_ff;
            `PPP_OFF_DIR_LOW: nxt_rdData = dirLow_ff;
            `PPP_OFF_DIR_HIGH: nxt_rdData = dirHigh_ff;
            `PPP_OFF_DATA_LOW: nxt_rdData = data_ff[`PPP_HALF_W-1:0];
            `PPP_OFF_DATA_HIGH:
                nxt_rdData = data_ff[`PPP_PIN_N-1:`PPP_HALF_W];
            default: nxt_rdData = `PPP_RST_RDATA;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_ff <= `PPP_RST_RDATA;
        end else if (regRdEn) begin
            rdData_ff <= nxt_rdData;
        end else begin
            rdData_ff <= `PPP_RST_RDATA;
        end
    end

    // pin drive value, registered so pins never glitch on decode
    always_ff @(posedge clk) begin
        if (rst) begin
            pinOut_ff <= '0;
        end else begin
            for (int i = 0; i < `PPP_PIN_N; i++) begin
                pinOut_ff[i] <= outFor(funcAll[i], funcOut[i], data_ff[i]);
            end
        end
    end

    // pin drive enable
    always_ff @(posedge clk) begin
        if (rst) begin
            pinOe_ff <= '0;
        end else begin
            for (int i = 0; i < `PPP_PIN_N; i++) begin
                pinOe_ff[i] <= oeFor(funcAll[i], funcOe[i]);
            end
        end
    end

    // pull-up control
    always_ff @(posedge clk) begin
        if (rst) begin
            pullUp_ff <= '0;
        end else begin
            for (int i = 0; i < `PPP_PIN_N; i++) begin
                pullUp_ff[i] <= pullUpFor(funcAll[i],
                                          isPullDownPin(i));
            end
        end
    end

    // pull-down control
    always_ff @(posedge clk) begin
        if (rst) begin
            pullDown_ff <= '0;
        end else begin
            for (int i = 0; i < `PPP_PIN_N; i++) begin
                pullDown_ff[i] <= pullDownFor(funcAll[i],
                                              isPullDownPin(i));
            end
        end
    end

    assign pinOut = pinOut_ff;
    assign pinOe = pinOe_ff;
    assign pinPullUp = pullUp_ff;
    assign pinPullDown = pullDown_ff;
    assign funcIn = pinLevel;
    assign regRdData = rdData_ff;
endmodule

// file: verif/ppp_port_properties.sv
// assertions on the pin port's register and pin outputs
`timescale 1ns/1ns
`include "ppp_defs.svh"
module ppp_port_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [`PPP_ADDR_W-1:0] regAddr,
    input wire logic [`PPP_HALF_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [`PPP_HALF_W-1:0] regRdData,
    // pins
    input wire logic [`PPP_PIN_N-1:0] pinOe,
    input wire logic [`PPP_PIN_N-1:0] pinPullUp,
    input wire logic [`PPP_PIN_N-1:0] pinPullDown
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_dir_wr;
        regWrEn && regAddr == `PPP_OFF_DIR_LOW;
    endsequence
    sequence s_dir_rd;
        regRdEn && regAddr == `PPP_OFF_DIR_LOW;
    endsequence
    a_dir_rd_back:
    assert property (s_dir_wr ##1 s_dir_rd |=> regRdData == $past(regWrData, 2))
        else $error("direction readback wrong");
    // mux is registered one edge after the register, hence two
    a_dir_low_gate:
    assert property (s_dir_wr |-> ##2 (pinOe[15:0] & $past(regWrData, 2)) == 0)
        else $error("input pin still driven");
    a_dir_high_gate:
    assert property (regWrEn && regAddr == `PPP_OFF_DIR_HIGH |->
        ##2 (pinOe[31:16] & $past(regWrData, 2)) == 16'h0000)
        else $error("high input pin still driven");
    a_unmapped_zero:
    assert property (regRdEn && (regAddr > 8'h7A || regAddr < 8'h70) |=>
        regRdData == 16'h0000) else $error("unmapped read not zero");
    a_reset_low_pulls:
    assert property ($fell(rst) |-> ##1 pinPullUp[15:0] == 16'hFC0D)
        else $error("low pins not pulled after reset");
    a_reset_high_pulls:
    assert property ($fell(rst) |->
        ##1 pinPullUp[31:16] inside {16'hFFFF, 16'hDBFF})
        else $error("high pins not pulled after reset");
    a_pull_down_pin:
    assert property ((pinPullDown & ~32'h2) == 0 && !pinPullUp[1])
        else $error("pull-down on wrong pin");
    a_pull_no_drive:
    assert property (((pinPullUp | pinPullDown) & pinOe) == 0)
        else $error("pulled pin also driven");
endmodule
bind ppp_port ppp_port_properties u_chk (.clk, .rst, .regAddr, .regWrData,
    .regWrEn, .regRdEn, .regRdData, .pinOe, .pinPullUp, .pinPullDown);

// file: verif/ppp_board_model.sv
// board model: pin levels seen by the port's input side
`timescale 1ns/1ns
module ppp_board_model (
    // clock for the floating-line pattern
    input wire logic clk,
    // device side of the pins
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pinOe,
    input wire logic [31:0] pinPullUp,
    input wire logic [31:0] pinPullDown,
    // board drivers
    input wire logic [31:0] extDrv,
    input wire logic [31:0] extEn,
    output logic [31:0] pinIn
);
    // floating lines wander so a stale level never reads as valid
    logic [31:0] flt = 32'h00000000;
    always @(posedge clk) flt <= ~flt;
    assign pinIn = (pinOe & pinOut)
        | (~pinOe & extEn & extDrv)
        | (~pinOe & ~extEn & (pinPullUp | (~pinPullDown & flt)));
endmodule

// file: verif/tb_top.sv
// random and corner-case bench for the pin port
`timescale 1ns/1ns
`include "ppp_defs.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic upperByteEnN = 1'b1;
    logic [31:0] funcOut = 32'h0, funcOe = 32'h0, extDrv = 32'h0, extEn = 32'h0;
    logic [15:0] regRdData;
    logic [31:0] pinIn, pinOut, pinOe, pinPullUp, pinPullDown, funcIn;
    logic [31:0] m, r, d, e;
    int err_total = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    ppp_port u_dut (.clk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData, .upperByteEnN, .pinIn, .pinOut, .pinOe, .pinPullUp,
        .pinPullDown, .funcOut, .funcOe, .funcIn);
    ppp_board_model u_board (.clk, .pinOut, .pinOe, .pinPullUp,
        .pinPullDown, .extDrv, .extEn, .pinIn);
    function automatic logic [31:0] eOe();
        return (m & ~r) | (~m & ~r & funcOe);
    endfunction
    function automatic logic [31:0] eOut();
        return ((m & ~r & d) | (~m & ~r & funcOut)) & eOe();
    endfunction
    function automatic logic [31:0] eRd();
        // undriven pulled inputs read their pull: up, except pin 1
        return (d & ~r) | (r & extEn & extDrv) | (r & ~extEn & ~32'h2);
    endfunction
    task automatic bus(input logic w, rd, input logic [7:0] a,
            input logic [15:0] v);
        @(posedge clk);
        regWrEn <= w;
        regRdEn <= rd;
        regAddr <= a;
        regWrData <= v;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        bus(1'b0, 1'b1, a, 16'h0000);
        bus(1'b0, 1'b0, a, 16'h0000);
        #1 chk({16'h0000, regRdData}, {16'h0000, exp});
    endtask
    // strap must stay put for the whole reset to clear the filter
    task automatic reset_run(input logic strap, input logic [15:0] hi);
        @(posedge clk);
        upperByteEnN <= strap;
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(`PPP_OFF_DIR_LOW, `PPP_RST_DIR_LOW);
        rd(`PPP_OFF_DIR_HIGH, hi);
        rd(`PPP_OFF_MODE_LOW, `PPP_RST_MODE);
        rd(`PPP_OFF_MODE_HIGH, `PPP_RST_MODE);
        chk(pinPullUp, {hi, 16'hFC0D});
        chk(pinPullDown, 32'h00000002);
        rd(8'h7C, 16'h0000);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'hf627fbd0));
        reset_run(1'b1, 16'hFFFF);
        for (int i = 0; i < 24; i++) begin
            m = $urandom();
            r = $urandom();
            d = $urandom();
            // all normal, all output, all input first
            if (i < 3) begin
                m = (i == 1) ? 32'hFFFFFFFF : 32'h0;
                r = (i == 2) ? 32'hFFFFFFFF : 32'h0;
            end
            @(posedge clk);
            funcOut <= $urandom();
            funcOe <= $urandom();
            extDrv <= $urandom();
            // only pulled inputs may be left undriven by the board
            extEn <= $urandom() | m | ~r;
            bus(1'b1, 1'b0, `PPP_OFF_MODE_LOW, m[15:0]);
            bus(1'b1, 1'b0, `PPP_OFF_MODE_HIGH, m[31:16]);
            bus(1'b1, 1'b0, `PPP_OFF_DIR_HIGH, r[31:16]);
            bus(1'b1, 1'b0, `PPP_OFF_DIR_LOW, r[15:0]);
            rd(`PPP_OFF_DIR_LOW, r[15:0]);
            bus(1'b1, 1'b0, `PPP_OFF_DATA_LOW, d[15:0]);
            bus(1'b1, 1'b0, `PPP_OFF_DATA_HIGH, d[31:16]);
            repeat (8) bus(1'b0, 1'b0, 8'h00, 16'h0000);
            #1 chk(pinOe, eOe());
            chk(pinOut & eOe(), eOut());
            chk(pinPullUp, ~m & r & ~32'h2);
            chk(pinPullDown, ~m & r & 32'h2);
            chk(funcIn, pinIn);
            rd(`PPP_OFF_MODE_HIGH, m[31:16]);
            e = eRd();
            rd(`PPP_OFF_DATA_LOW, e[15:0]);
            rd(`PPP_OFF_DATA_HIGH, e[31:16]);
        end
        reset_run(1'b0, 16'hDBFF);
        stop_test();
    end
endmodule
